// [inc/frtc_pkg.sv]
// Behaviour
// - 16-bit up counter, one step per tick
// - Clock select: cpu/2, /4, /8, external
// - Main and shadow views show live count
// - Low byte write loads FFFC
// - Reset loads FFFC, no load besides low write
// - Wrap FFFF to 0000 sets rollover flag
// - High byte read captures low byte
// - Held low byte frozen until low read
// - After sequence, low read returns live byte
// - Irq when flag, enable, mask clear
// - Flag clears: status read then main low
// - Shadow low access never clears flag
// - Counting continues during wait
// - Halt stops counter, resumes held count
package frtc_pkg;
   localparam logic [15:0] CNT_RESET    = 16'hFFFC;
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;
   localparam logic [3:0]  ADDR_CHI     = 4'h0;
   localparam logic [3:0]  ADDR_CLO     = 4'h1;
   localparam logic [3:0]  ADDR_SHI     = 4'h2;
   localparam logic [3:0]  ADDR_SLO     = 4'h3;
   localparam logic [3:0]  ADDR_FLAGS   = 4'h4;
   localparam logic [3:0]  ADDR_CTL1    = 4'h5;
   localparam logic [3:0]  ADDR_CTL2    = 4'h6;
   localparam int          FLAG_ROLL    = 7;
   localparam int          CTL1_IRQEN   = 5;
   localparam logic [1:0]  CS_DIV2      = 2'h0;
   localparam logic [1:0]  CS_DIV4      = 2'h1;
   localparam logic [1:0]  CS_DIV8      = 2'h2;
   localparam logic [1:0]  CS_EXT       = 2'h3;
   localparam logic [2:0]  PRE_MASK2    = 3'h1;
   localparam logic [2:0]  PRE_MASK4    = 3'h3;
   localparam logic [2:0]  PRE_MASK8    = 3'h7;
   localparam logic [31:0] BAD_READ     = 32'h0000_0000;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [3:0] idx;
      logic [7:0] wdata;
   } frtc_req_t;
endpackage

// [rtl/frtc_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser with rising-edge pulse on agreement
module frtc_sync (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic srst,
   // Pin and result
   input  wire logic pin,
   output logic      rise
);
   logic s1;
   logic s2;
   logic s3;
   logic lvl;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s1  <= 1'b0;
         s2  <= 1'b0;
         s3  <= 1'b0;
         lvl <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            lvl <= s3;
         end
      end
   end

   assign rise = (s2 == s3) && s3 && !lvl;
endmodule
`default_nettype wire

// [rtl/frtc_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module frtc_timer (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // Avalon-MM slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // System
   input  wire logic        ext_clk,
   input  wire logic        halt_mode,
   input  wire logic        wait_mode,
   input  wire logic        cpu_irq_mask,
   // Outputs
   output logic             timer_irq,
   output logic [15:0]      live_count_view
);
   logic [15:0] count;
   logic [7:0]  held_low;
   logic        held_valid;
   logic        rollover_flag;
   logic        flag_armed;
   logic [7:0]  timer_control_one;
   logic [7:0]  timer_control_two;
   logic [2:0]  prescale;
   logic        acked;
   logic [31:0] rdata;

   // Bus decode
   frtc_pkg::frtc_req_t req;
   wire acc      = (avs_read || avs_write) && !acked;
   wire word_ok  = (avs_address[1:0] == 2'h0);
   assign req.rd    = avs_read && acc;
   assign req.wr    = avs_write && acc && avs_byteenable[0];
   assign req.idx   = avs_address[5:2];
   assign req.wdata = avs_writedata[7:0];
   wire hit_chi  = word_ok && req.idx == frtc_pkg::ADDR_CHI;
   wire hit_clo  = word_ok && req.idx == frtc_pkg::ADDR_CLO;
   wire hit_shi  = word_ok && req.idx == frtc_pkg::ADDR_SHI;
   wire hit_slo  = word_ok && req.idx == frtc_pkg::ADDR_SLO;
   wire hit_flg  = word_ok && req.idx == frtc_pkg::ADDR_FLAGS;
   wire hit_c1   = word_ok && req.idx == frtc_pkg::ADDR_CTL1;
   wire hit_c2   = word_ok && req.idx == frtc_pkg::ADDR_CTL2;
   wire hit_any  = hit_chi || hit_clo || hit_shi || hit_slo || hit_flg || hit_c1 || hit_c2;
   wire hi_read  = req.rd && (hit_chi || hit_shi);
   wire lo_read  = req.rd && (hit_clo || hit_slo);
   wire lo_write = req.wr && (hit_clo || hit_slo);
   wire main_lo  = (req.rd || req.wr) && hit_clo;
   wire flg_read = req.rd && hit_flg;

   // Prescaler and tick select
   wire [1:0] clock_select = timer_control_two[1:0];
   wire       ext_rise;
   wire [2:0] pre_mask = (clock_select == frtc_pkg::CS_DIV2) ? frtc_pkg::PRE_MASK2 :
                         (clock_select == frtc_pkg::CS_DIV4) ? frtc_pkg::PRE_MASK4 :
                                                               frtc_pkg::PRE_MASK8;
   wire       int_tick = ((prescale & pre_mask) == pre_mask);
   wire       tick     = !halt_mode && ((clock_select == frtc_pkg::CS_EXT) ? ext_rise : int_tick);
   wire       wrap     = tick && (count == frtc_pkg::CNT_MAX);
   wire [15:0] next_count = count + 16'h0001;

   frtc_sync u_sync (
      .sys_clk (sys_clk),
      .srst    (srst),
      .pin     (ext_clk),
      .rise    (ext_rise)
   );

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         prescale <= 3'h0;
      end else if (!halt_mode) begin
         prescale <= prescale + 3'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst || lo_write) begin
         count <= frtc_pkg::CNT_RESET;
      end else if (tick) begin
         count <= next_count;
      end
   end

   // Low byte capture on high read
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         held_low   <= 8'h00;
         held_valid <= 1'b0;
      end else if (lo_read) begin
         held_valid <= 1'b0;
      end else if (hi_read && !held_valid) begin
         held_low   <= count[7:0];
         held_valid <= 1'b1;
      end
   end

   // Rollover flag and two-step clear, set wins
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rollover_flag <= 1'b0;
         flag_armed    <= 1'b0;
      end else begin
         if (wrap) begin
            rollover_flag <= 1'b1;
         end else if (main_lo && flag_armed) begin
            rollover_flag <= 1'b0;
         end
         if (flg_read && rollover_flag) begin
            flag_armed <= 1'b1;
         end else if (main_lo || !rollover_flag) begin
            flag_armed <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         timer_control_one <= 8'h00;
         timer_control_two <= 8'h00;
      end else begin
         if (req.wr && hit_c1) begin
            timer_control_one <= req.wdata;
         end
         if (req.wr && hit_c2) begin
            timer_control_two <= req.wdata;
         end
      end
   end

   // Read mux
   wire [7:0] lo_val = held_valid ? held_low : count[7:0];
   always_comb begin
      rdata = frtc_pkg::BAD_READ;
      if (hit_chi || hit_shi) begin
         rdata[7:0] = count[15:8];
      end else if (hit_clo || hit_slo) begin
         rdata[7:0] = lo_val;
      end else if (hit_flg) begin
         rdata[frtc_pkg::FLAG_ROLL] = rollover_flag;
      end else if (hit_c1) begin
         rdata[7:0] = timer_control_one;
      end else if (hit_c2) begin
         rdata[7:0] = timer_control_two;
      end
   end

   // One wait cycle, answer on second edge
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         acked        <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         acked <= acc;
         if (req.rd) begin
            avs_readdata <= rdata;
         end
      end
   end
   assign avs_waitrequest = !acked;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= rollover_flag && timer_control_one[frtc_pkg::CTL1_IRQEN] && !cpu_irq_mask;
      end
   end
   assign live_count_view = count;

   a_count_step: assert property (@(posedge sys_clk) disable iff (srst)
      tick && !lo_write |=> count == $past(count) + 16'h0001) else $error("count step wrong");
   a_load_ffc: assert property (@(posedge sys_clk) disable iff (srst)
      lo_write |=> count == frtc_pkg::CNT_RESET) else $error("low write load wrong");
   a_halt_hold: assert property (@(posedge sys_clk) disable iff (srst)
      halt_mode && !lo_write |=> $stable(count)) else $error("count moved in halt");
   a_wrap_flag: assert property (@(posedge sys_clk) disable iff (srst)
      wrap |=> rollover_flag) else $error("wrap missed flag");
   a_shadow_keep: assert property (@(posedge sys_clk) disable iff (srst)
      rollover_flag && !main_lo |=> rollover_flag) else $error("flag lost");
   a_held_frozen: assert property (@(posedge sys_clk) disable iff (srst)
      held_valid && !lo_read |=> held_valid && $stable(held_low)) else $error("held byte moved");
   a_hi_capture: assert property (@(posedge sys_clk) disable iff (srst)
      hi_read && !held_valid && !lo_read |=> held_low == $past(count[7:0])) else $error("capture wrong");
   a_irq_gate: assert property (@(posedge sys_clk) disable iff (srst)
      timer_irq |-> $past(rollover_flag) && !$past(cpu_irq_mask)) else $error("spurious irq");
   a_div2_rate: assert property (@(posedge sys_clk) disable iff (srst)
      tick && clock_select == frtc_pkg::CS_DIV2 && !halt_mode ##1 clock_select == frtc_pkg::CS_DIV2
      |-> !tick) else $error("div2 ticks too fast");

   // Enabled cycles since the last tick, for the rate checks
   logic [3:0] gap;
   logic       gap_seen;
   logic [1:0] gap_sel;
   wire        gap_new = (clock_select != gap_sel);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gap      <= 4'h0;
         gap_seen <= 1'b0;
         gap_sel  <= frtc_pkg::CS_DIV2;
      end else begin
         gap_sel <= clock_select;
         if (tick || gap_new) begin
            gap <= 4'h0;
         end else if (!halt_mode && gap != 4'hF) begin
            gap <= gap + 4'h1;
         end
         if (gap_new) begin
            gap_seen <= 1'b0;
         end else if (tick) begin
            gap_seen <= 1'b1;
         end
      end
   end

   // Counter loads and wrap
   a_reset_load: assert property (@(posedge sys_clk)
      srst
      |=> count == frtc_pkg::CNT_RESET)
      else $error("reset did not load count");
   a_no_other_load: assert property (@(posedge sys_clk) disable iff (srst)
      !lo_write && !tick
      |=> $stable(count))
      else $error("count changed without tick");
   a_wrap_zero: assert property (@(posedge sys_clk) disable iff (srst)
      wrap && !lo_write
      |=> count == '0)
      else $error("wrap did not reach zero");
   a_flag_only_wrap: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(rollover_flag)
      |-> $past(wrap))
      else $error("flag set without wrap");
   a_flag_read: assert property (@(posedge sys_clk) disable iff (srst)
      flg_read
      |=> avs_readdata[frtc_pkg::FLAG_ROLL] == $past(rollover_flag))
      else $error("flag read value wrong");

   // Interrupt and two-step clear
   a_irq_raise: assert property (@(posedge sys_clk) disable iff (srst)
      rollover_flag && timer_control_one[frtc_pkg::CTL1_IRQEN] && !cpu_irq_mask
      |=> timer_irq)
      else $error("irq not raised");
   a_irq_drop: assert property (@(posedge sys_clk) disable iff (srst)
      !(rollover_flag && timer_control_one[frtc_pkg::CTL1_IRQEN] && !cpu_irq_mask)
      |=> !timer_irq)
      else $error("irq not dropped");
   a_flag_clear: assert property (@(posedge sys_clk) disable iff (srst)
      main_lo && flag_armed && !wrap
      |=> !rollover_flag)
      else $error("armed flag not cleared");
   a_flag_arm: assert property (@(posedge sys_clk) disable iff (srst)
      flg_read && rollover_flag
      |=> flag_armed)
      else $error("status read did not arm");
   a_flag_fall: assert property (@(posedge sys_clk) disable iff (srst)
      $fell(rollover_flag)
      |-> $past(main_lo) && $past(flag_armed))
      else $error("flag cleared out of sequence");
   a_shadow_flag: assert property (@(posedge sys_clk) disable iff (srst)
      rollover_flag && hit_slo && (req.rd || req.wr)
      |=> rollover_flag)
      else $error("shadow access cleared flag");

   // Read sequence
   a_lo_release: assert property (@(posedge sys_clk) disable iff (srst)
      lo_read
      |=> !held_valid)
      else $error("low read kept hold");
   a_lo_live: assert property (@(posedge sys_clk) disable iff (srst)
      lo_read && !held_valid
      |=> avs_readdata[7:0] == $past(count[7:0]))
      else $error("live low byte wrong");
   a_lo_held: assert property (@(posedge sys_clk) disable iff (srst)
      lo_read && held_valid
      |=> avs_readdata[7:0] == $past(held_low))
      else $error("held low byte not returned");
   a_lo_load_held: assert property (@(posedge sys_clk) disable iff (srst)
      lo_write && held_valid && !lo_read
      |=> held_valid)
      else $error("low write released hold");
   a_hi_data: assert property (@(posedge sys_clk) disable iff (srst)
      hi_read
      |=> avs_readdata[7:0] == $past(count[15:8]))
      else $error("high byte wrong");

   // Rates and low-power modes
   a_wait_runs: assert property (@(posedge sys_clk) disable iff (srst)
      wait_mode && tick && !lo_write
      |=> count != $past(count))
      else $error("count stalled in wait");
   a_halt_prescale: assert property (@(posedge sys_clk) disable iff (srst)
      halt_mode
      |=> $stable(prescale))
      else $error("prescaler ran in halt");
   a_pre_step: assert property (@(posedge sys_clk) disable iff (srst)
      !halt_mode
      |=> prescale == $past(prescale) + 3'h1)
      else $error("prescaler step wrong");
   a_ext_pin: assert property (@(posedge sys_clk) disable iff (srst)
      tick && clock_select == frtc_pkg::CS_EXT
      |-> $past(ext_clk, 2) && $past(ext_clk, 3))
      else $error("external tick without settled pin");
   a_div2_gap: assert property (@(posedge sys_clk) disable iff (srst)
      gap_seen && !gap_new && !halt_mode && clock_select == frtc_pkg::CS_DIV2
      |-> tick == (gap == {1'b0, frtc_pkg::PRE_MASK2}))
      else $error("div2 tick spacing wrong");
   a_div4_gap: assert property (@(posedge sys_clk) disable iff (srst)
      gap_seen && !gap_new && !halt_mode && clock_select == frtc_pkg::CS_DIV4
      |-> tick == (gap == {1'b0, frtc_pkg::PRE_MASK4}))
      else $error("div4 tick spacing wrong");
   a_div8_gap: assert property (@(posedge sys_clk) disable iff (srst)
      gap_seen && !gap_new && !halt_mode && clock_select == frtc_pkg::CS_DIV8
      |-> tick == (gap == {1'b0, frtc_pkg::PRE_MASK8}))
      else $error("div8 tick spacing wrong");

   // Bus behaviour
   a_bad_read: assert property (@(posedge sys_clk) disable iff (srst)
      req.rd && !hit_any
      |=> avs_readdata == frtc_pkg::BAD_READ)
      else $error("unmapped read not zero");
   a_ctl_write: assert property (@(posedge sys_clk) disable iff (srst)
      req.wr && hit_c2
      |=> timer_control_two == $past(req.wdata))
      else $error("control two write lost");
   a_ctl1_write: assert property (@(posedge sys_clk) disable iff (srst)
      req.wr && hit_c1
      |=> timer_control_one == $past(req.wdata))
      else $error("control one write lost");
   a_be_gate: assert property (@(posedge sys_clk) disable iff (srst)
      acc && avs_write && !avs_byteenable[0]
      |=> $stable(timer_control_one) && $stable(timer_control_two))
      else $error("masked write took effect");
   a_wait_one: assert property (@(posedge sys_clk) disable iff (srst)
      acc
      |=> !avs_waitrequest)
      else $error("request not answered");
   a_wait_drop: assert property (@(posedge sys_clk) disable iff (srst)
      !avs_waitrequest
      |=> avs_waitrequest)
      else $error("answer held too long");
   a_rd_stable: assert property (@(posedge sys_clk) disable iff (srst)
      !req.rd
      |=> $stable(avs_readdata))
      else $error("read data moved without read");
endmodule
`default_nettype wire

// [tb/free_running_timer_counter_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module free_running_timer_counter_tb;
   logic        sys_clk = 0, srst = 1, ext_clk = 0, halt_mode = 1, wait_mode = 0, cpu_irq_mask = 1;
   logic [5:0]  avs_address = 0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic        avs_read = 0, avs_write = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, q;
   logic        avs_waitrequest, timer_irq;
   logic [15:0] live_count_view, v;
   int          failures = 0, checks_done = 0, cyc = 0;

   frtc_timer u_dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_clk(ext_clk),
      .halt_mode(halt_mode), .wait_mode(wait_mode), .cpu_irq_mask(cpu_irq_mask),
      .timer_irq(timer_irq), .live_count_view(live_count_view));

   always #50 sys_clk = ~sys_clk;

   task automatic test_done();
      if (failures == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rd16(input logic [5:0] hi);
      bus(0, hi, 8'h00);
      v[15:8] = q[7:0];
      bus(0, hi + 6'h04, 8'h00);
      v[7:0] = q[7:0];
   endtask

   // Let the counter run n cycles, ext_clk toggling every 4 cycles
   task automatic run(input int n);
      @(posedge sys_clk);
      halt_mode <= 1'b0;
      for (int i = 1; i <= n; i++) begin
         @(posedge sys_clk);
         if (i % 4 == 0) ext_clk <= ~ext_clk;
      end
      halt_mode <= 1'b1;
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic near(input logic [15:0] d, input int e);
      chk({31'h0, (int'(d) >= e - 1 && int'(d) <= e + 1)}, 32'h1);
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         test_done();
      end
   end

   initial begin
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      chk(live_count_view, 32'hFFFC);
      rd16(6'h00); chk(v, 32'hFFFC);
      rd16(6'h08); chk(v, 32'hFFFC);
      bus(0, 6'h00, 0);
      wait_mode <= 1'b1;
      run(20);
      bus(0, 6'h00, 0); chk(q, 32'h00);
      bus(0, 6'h04, 0); chk(q, 32'hFC);
      rd16(6'h00); near(v + 16'h0004, 10);
      bus(0, 6'h10, 0); chk(q[7], 1);
      bus(1, 6'h14, 8'h20);
      repeat (3) @(posedge sys_clk);
      chk(timer_irq, 0);
      cpu_irq_mask <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(timer_irq, 1);
      bus(0, 6'h10, 0);
      bus(0, 6'h0C, 0);
      bus(1, 6'h0C, 0);
      bus(0, 6'h10, 0); chk(q[7], 1);
      bus(0, 6'h04, 0);
      bus(0, 6'h10, 0); chk(q[7], 0);
      repeat (3) @(posedge sys_clk);
      chk(timer_irq, 0);
      rd16(6'h08);
      run(6);
      bus(0, 6'h0C, 0); near(q[7:0] - v[7:0], 3);
      bus(1, 6'h04, 8'h55);
      rd16(6'h00); chk(v, 32'hFFFC);
      run(10);
      bus(1, 6'h0C, 8'h00);
      rd16(6'h08); chk(v, 32'hFFFC);
      for (int cs = 0; cs < 4; cs++) begin
         bus(1, 6'h18, 8'(cs));
         bus(1, 6'h04, 0);
         run(64);
         rd16(6'h00); near(v + 16'h0004, (cs == 3) ? 8 : 64 >> (cs + 1));
      end
      bus(0, 6'h3C, 0); chk(q, 32'h0);
      bus(0, 6'h01, 0); chk(q, 32'h0);
      // Write with byte lane 0 off must be ignored
      avs_byteenable <= 4'h0;
      bus(1, 6'h18, 8'h01);
      avs_byteenable <= 4'hF;
      bus(0, 6'h18, 8'h00); chk(q, 32'h3);
      bus(0, 6'h14, 8'h00); chk(q, 32'h20);
      // Reset while halted, with the flag and irq up
      srst <= 1'b1;
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      chk(live_count_view, 32'hFFFC);
      chk(timer_irq, 32'h0);
      bus(0, 6'h10, 8'h00); chk(q, 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
